// File: rtl/mda_route_decode.sv
// Decodes legacy display references and picks their destination
`default_nettype none
module mda_route_decode (
  input wire serr_pkg::route_req_t req,
  input wire logic vga_en,
  input wire logic mono_display_present,
  output serr_pkg::route_res_t res
);

  logic [9:0] io_a;
  logic mem_vga;
  logic mem_mono;
  logic io_vga;
  logic io_mono;
  logic vga_hit;
  logic mono_hit;

  // ----------------------------------------
  // Address match, upper I/O bits ignored
  // ----------------------------------------
  assign io_a = req.addr[9:0];
  assign mem_vga = (req.addr >= serr_pkg::VGA_MEM_LO) && (req.addr <= serr_pkg::VGA_MEM_HI);
  assign mem_mono = (req.addr >= serr_pkg::MONO_MEM_LO) && (req.addr <= serr_pkg::MONO_MEM_HI);
  assign io_vga = ((io_a >= serr_pkg::VGA_IO_LO_A) && (io_a <= serr_pkg::VGA_IO_HI_A))
                || ((io_a >= serr_pkg::VGA_IO_LO_B) && (io_a <= serr_pkg::VGA_IO_HI_B));
  assign io_mono = (io_a == serr_pkg::MONO_IO_P0) || (io_a == serr_pkg::MONO_IO_P1)
                 || (io_a == serr_pkg::MONO_IO_P2) || (io_a == serr_pkg::MONO_IO_P3)
                 || (io_a == serr_pkg::MONO_IO_P4) || (io_a == serr_pkg::MONO_IO_P5); // [RULE_05]
  assign vga_hit = req.is_io ? io_vga : mem_vga;
  assign mono_hit = req.is_io ? io_mono : mem_mono; // [RULE_05]

  // ----------------------------------------
  // Destination: hub unless VGA owned by graphics port
  // ----------------------------------------
  // Cleared enable sends all to hub; present bit alone is ignored [RULE_01] [RULE_02]
  // Present bit pulls mono references back to hub [RULE_03] [RULE_04]
  assign res.valid = req.valid;
  assign res.vga_hit = vga_hit;
  assign res.mono_hit = mono_hit;
  assign res.to_agp = vga_en && vga_hit && !(mono_display_present && mono_hit);

endmodule : mda_route_decode
`default_nettype wire

// File: rtl/serr_error_report.sv
// Error message enables, message sender and legacy display routing
// Notes on behaviour
// RULE_01: Both bits clear: all display references to hub.
// RULE_02: Software never sets present without VGA enable.
// RULE_03: VGA only: all VGA references to graphics port.
// RULE_04: Both set: VGA to port, mono to hub.
// RULE_05: Mono ranges: B0000-B7FFF, listed ports, aliased.
// RULE_06: VGA enable is bridge control bit 3.
// RULE_07: Enabled condition sends one error message to hub.
// RULE_08: Global error enable gates every message.
// RULE_09: Enables act only in graphics port mode.
// RULE_10: One occurrence yields exactly one message.
// RULE_11: Software disables other alerts for enabled conditions.
// RULE_12: Bit 5: refresh overrun sends message.
// RULE_13: Bit 4: target abort on own cycle.
// RULE_14: Bit 3: locked access to non-DRAM memory.
// RULE_15: Bit 2: graphics access outside aperture.
// RULE_16: Bit 1: outside aperture and low/high invalid.
// RULE_17: Bit 0: invalid translation table entry.
// RULE_18: Cleared bit suppresses; bits 7:6 reserved.
// RULE_19: Each condition counts once per occurrence.
`default_nettype none
module serr_error_report (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [serr_pkg::COND_N-1:0] err_event,
  output logic msg_valid,
  output serr_pkg::serr_msg_t msg,
  input wire logic msg_ready,
  input wire serr_pkg::route_req_t route_req,
  output serr_pkg::route_res_t route_res
);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic [7:0] err_en_q;
  logic [7:0] bridge_ctrl_q;
  logic [7:0] hub_cfg_q;
  localparam int COND_W = serr_pkg::COND_N;
  logic [COND_W-1:0] pend_q;
  logic [COND_W-1:0] pend_d;
  logic [7:0] sent_cnt_q;
  logic wr_q;
  logic rd_q;
  logic [9:0] dp_addr_q;
  logic ap_take;
  logic [31:0] rd_mux;
  logic [31:0] stat_word;

  assign ap_take = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      dp_addr_q <= 10'h000;
    end
    else if (hready)
    begin
      wr_q <= ap_take && hwrite;
      rd_q <= ap_take && !hwrite;
      dp_addr_q <= haddr[9:0];
    end
  end

  logic hit_err_en;
  logic hit_bridge;
  logic hit_cfg;
  logic hit_stat;
  logic upper_zero;
  logic [31:0] hi_addr;

  // Only the low ten address bits select; anything above must be zero
  assign hi_addr = haddr;
  logic [21:0] dp_hi_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dp_hi_q <= 22'h000000;
    else if (hready)
      dp_hi_q <= hi_addr[31:10];
  end
  assign upper_zero = (dp_hi_q == 22'h000000);
  assign hit_err_en = upper_zero && (dp_addr_q == serr_pkg::ADDR_ERR_EN);
  assign hit_bridge = upper_zero && (dp_addr_q == serr_pkg::ADDR_BRIDGE_CTRL);
  assign hit_cfg = upper_zero && (dp_addr_q == serr_pkg::ADDR_HUB_CFG);
  assign hit_stat = upper_zero && (dp_addr_q == serr_pkg::ADDR_MSG_STAT);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      err_en_q <= serr_pkg::ERR_EN_RST;
    else if (wr_q && hit_err_en)
      err_en_q <= hwdata[7:0] & serr_pkg::ERR_EN_MASK; // [RULE_18]
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bridge_ctrl_q <= serr_pkg::BRIDGE_CTRL_RST;
    else if (wr_q && hit_bridge)
      bridge_ctrl_q <= hwdata[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hub_cfg_q <= serr_pkg::HUB_CFG_RST;
    else if (wr_q && hit_cfg)
      hub_cfg_q <= hwdata[7:0] & serr_pkg::HUB_CFG_MASK;
  end

  logic vga_en;
  logic mono_present;
  logic serr_global;
  logic agp_mode;

  assign vga_en = bridge_ctrl_q[serr_pkg::BIT_VGA_EN]; // [RULE_06]
  assign mono_present = hub_cfg_q[serr_pkg::BIT_MONO_PRESENT];
  assign serr_global = hub_cfg_q[serr_pkg::BIT_SERR_GLOBAL];
  assign agp_mode = hub_cfg_q[serr_pkg::BIT_AGP_MODE];

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  serr_pkg::msg_state_t state_q;
  serr_pkg::msg_state_t state_d;

  assign stat_word = {8'h00, sent_cnt_q, 7'h00, (state_q == serr_pkg::MSG_SEND),
                      2'b00, pend_q};
  assign rd_mux = hit_err_en ? {24'h000000, err_en_q}
                : hit_bridge ? {24'h000000, bridge_ctrl_q}
                : hit_cfg ? {24'h000000, hub_cfg_q}
                : hit_stat ? stat_word
                : 32'h0000_0000;
  assign hrdata = rd_q ? rd_mux : 32'h0000_0000;

  // ----------------------------------------
  // Condition occurrences and gating
  // ----------------------------------------
  logic [COND_W-1:0] occur;
  logic [COND_W-1:0] gate;
  logic [COND_W-1:0] fire;
  logic [COND_W-1:0] clr;

  serr_event_edge u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .level_in(err_event),
    .pulse_out(occur)
  ); // [RULE_19]

  // Per-condition enables [RULE_12] [RULE_13] [RULE_14] [RULE_15] [RULE_16] [RULE_17]
  // Global enable and mode gate everything [RULE_08] [RULE_09]
  assign gate = err_en_q[COND_W-1:0] & {COND_W{serr_global && agp_mode}}; // [RULE_18]
  assign fire = occur & gate; // [RULE_07]

  // Pending flags: new occurrence wins over the clear of its own send
  assign pend_d = ((pend_q & ~clr) | fire) & gate; // [RULE_10]

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pend_q <= '0;
    else
      pend_q <= pend_d;
  end

  // ----------------------------------------
  // Message sender, lowest pending bit first
  // ----------------------------------------
  logic [2:0] pick;
  logic any_pend;
  logic accept;

  always_comb
  begin
    pick = 3'd0;
    for (int i = COND_W - 1; i >= 0; i--)
    begin
      if (pend_q[i])
        pick = 3'(i);
    end
  end

  assign any_pend = |pend_q;
  assign accept = (state_q == serr_pkg::MSG_SEND) && msg_ready;
  assign msg_valid = (state_q == serr_pkg::MSG_SEND);
  assign clr = accept ? (COND_W'(1) << msg.cause) : '0; // [RULE_10]

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      serr_pkg::MSG_IDLE:
      begin
        if (any_pend)
          state_d = serr_pkg::MSG_SEND;
      end
      serr_pkg::MSG_SEND:
      begin
        if (msg_ready)
          state_d = serr_pkg::MSG_IDLE;
      end
      default:
        state_d = serr_pkg::MSG_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_q <= serr_pkg::MSG_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      msg <= '0;
    else if ((state_q == serr_pkg::MSG_IDLE) && any_pend)
      msg.cause <= pick; // [RULE_07]
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sent_cnt_q <= 8'h00;
    else if (accept)
      sent_cnt_q <= sent_cnt_q + 8'h01;
  end

  // ----------------------------------------
  // Legacy display routing
  // ----------------------------------------
  serr_pkg::route_res_t dec_res;

  mda_route_decode u_route (
    .req(route_req),
    .vga_en(vga_en),
    .mono_display_present(mono_present),
    .res(dec_res)
  ); // [RULE_01] [RULE_03] [RULE_04]

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      route_res <= '0;
    else
      route_res <= dec_res;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic mono_mem_req;
  assign mono_mem_req = route_req.valid && !route_req.is_io
                     && (route_req.addr >= serr_pkg::MONO_MEM_LO)
                     && (route_req.addr <= serr_pkg::MONO_MEM_HI);

  AST_ROUTE_ALL_HUB: assert property ( // [RULE_01]
    @(posedge hclk) disable iff (!hresetn)
    route_res.valid && !$past(vga_en) |-> !route_res.to_agp)
    else $error("display reference left hub with VGA enable clear");

  AST_ROUTE_VGA_AGP: assert property ( // [RULE_03]
    @(posedge hclk) disable iff (!hresetn)
    route_res.valid && route_res.vga_hit && $past(vga_en && !mono_present)
    |-> route_res.to_agp)
    else $error("VGA reference not sent to graphics port");

  AST_ROUTE_MONO_HUB: assert property ( // [RULE_04]
    @(posedge hclk) disable iff (!hresetn)
    route_res.valid && route_res.mono_hit && $past(vga_en && mono_present)
    |-> !route_res.to_agp)
    else $error("mono reference not sent to hub");

  AST_MONO_MEM_HIT: assert property ( // [RULE_05]
    @(posedge hclk) disable iff (!hresetn)
    mono_mem_req |=> route_res.valid && route_res.mono_hit)
    else $error("mono memory range missed");

  AST_MSG_HOLD: assert property ( // [RULE_07]
    @(posedge hclk) disable iff (!hresetn)
    msg_valid && !msg_ready |=> msg_valid && $stable(msg))
    else $error("message dropped before accept");

  AST_GLOBAL_GATE: assert property ( // [RULE_08]
    @(posedge hclk) disable iff (!hresetn)
    (pend_q != '0) |-> $past(serr_global))
    else $error("pending message without global enable");

  AST_MODE_GATE: assert property ( // [RULE_09]
    @(posedge hclk) disable iff (!hresetn)
    (pend_q != '0) |-> $past(agp_mode))
    else $error("pending message outside graphics port mode");

  AST_ONE_PER_EVENT: assert property ( // [RULE_10]
    @(posedge hclk) disable iff (!hresetn)
    accept |=> (pend_q[$past(msg.cause)] == $past(fire[msg.cause])))
    else $error("one occurrence sent twice");

  AST_FIRE_LATENCY: assert property ( // [RULE_07]
    @(posedge hclk) disable iff (!hresetn)
    (fire != '0) && (pend_q == '0) && !msg_valid |-> ##2 msg_valid)
    else $error("enabled event not sent within two cycles");

  AST_SUPPRESS: assert property ( // [RULE_18]
    @(posedge hclk) disable iff (!hresetn)
    (pend_q & ~$past(err_en_q[COND_W-1:0])) == '0)
    else $error("disabled condition is pending");

  AST_NO_REPEAT: assert property ( // [RULE_19]
    @(posedge hclk) disable iff (!hresetn)
    (fire & $past(fire)) == '0)
    else $error("held condition fired twice in a row");

  AST_RSVD_ZERO: assert property ( // [RULE_18]
    @(posedge hclk) disable iff (!hresetn)
    err_en_q[7:6] == 2'b00)
    else $error("reserved enable bits set");

  COV_MSG_SENT: cover property (
    @(posedge hclk) disable iff (!hresetn)
    accept);

  COV_VGA_TO_AGP: cover property (
    @(posedge hclk) disable iff (!hresetn)
    route_res.valid && route_res.to_agp);

  COV_MONO_TO_HUB: cover property (
    @(posedge hclk) disable iff (!hresetn)
    route_res.valid && route_res.mono_hit && !route_res.to_agp && $past(vga_en));

  COV_SET_AND_CLEAR: cover property (
    @(posedge hclk) disable iff (!hresetn)
    accept && fire[msg.cause]);

endmodule : serr_error_report
`default_nettype wire

// File: rtl/serr_event_edge.sv
// Turns condition levels into one-cycle occurrence pulses
`default_nettype none
module serr_event_edge (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [serr_pkg::COND_N-1:0] level_in,
  output logic [serr_pkg::COND_N-1:0] pulse_out
);

  logic [serr_pkg::COND_N-1:0] prev_q;

  // ----------------------------------------
  // Rising edge per condition
  // ----------------------------------------
  for (genvar i = 0; i < serr_pkg::COND_N; i++)
  begin : g_cond
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        prev_q[i] <= 1'b0;
      else
        prev_q[i] <= level_in[i];
    end
    assign pulse_out[i] = level_in[i] & ~prev_q[i];
  end

endmodule : serr_event_edge
`default_nettype wire

// File: rtl/serr_pkg.sv
// Shared constants and types for the error message and display routing block
`default_nettype none
package serr_pkg;

  // ----------------------------------------
  // Register map (index, byte address = 4 x index)
  // ----------------------------------------
  localparam logic [7:0] IDX_ERR_EN = 8'hcb;
  localparam logic [7:0] IDX_BRIDGE_CTRL = 8'h3e;
  localparam logic [7:0] IDX_HUB_CFG = 8'hc0;
  localparam logic [7:0] IDX_MSG_STAT = 8'hc1;
  localparam logic [9:0] ADDR_ERR_EN = {IDX_ERR_EN, 2'b00};
  localparam logic [9:0] ADDR_BRIDGE_CTRL = {IDX_BRIDGE_CTRL, 2'b00};
  localparam logic [9:0] ADDR_HUB_CFG = {IDX_HUB_CFG, 2'b00};
  localparam logic [9:0] ADDR_MSG_STAT = {IDX_MSG_STAT, 2'b00};

  // ----------------------------------------
  // Reset values and field positions
  // ----------------------------------------
  localparam logic [7:0] ERR_EN_RST = 8'h00;
  localparam logic [7:0] BRIDGE_CTRL_RST = 8'h00;
  localparam logic [7:0] HUB_CFG_RST = 8'h00;
  localparam logic [7:0] ERR_EN_MASK = 8'h3f;
  localparam logic [7:0] HUB_CFG_MASK = 8'h07;
  localparam int COND_N = 6;
  localparam int BIT_BAD_XLAT = 0;
  localparam int BIT_INVALID_AGP = 1;
  localparam int BIT_OUTSIDE_APERTURE = 2;
  localparam int BIT_LOCKED_NON_DRAM = 3;
  localparam int BIT_TARGET_ABORT = 4;
  localparam int BIT_REFRESH_OVERRUN = 5;
  localparam int BIT_VGA_EN = 3;
  localparam int BIT_SERR_GLOBAL = 0;
  localparam int BIT_AGP_MODE = 1;
  localparam int BIT_MONO_PRESENT = 2;
  localparam int STAT_BUSY = 8;
  localparam int STAT_CNT_LSB = 16;

  // ----------------------------------------
  // Legacy display decode ranges
  // ----------------------------------------
  localparam logic [31:0] MONO_MEM_LO = 32'h000b_0000;
  localparam logic [31:0] MONO_MEM_HI = 32'h000b_7fff;
  localparam logic [31:0] VGA_MEM_LO = 32'h000a_0000;
  localparam logic [31:0] VGA_MEM_HI = 32'h000b_ffff;
  localparam logic [9:0] VGA_IO_LO_A = 10'h3b0;
  localparam logic [9:0] VGA_IO_HI_A = 10'h3bb;
  localparam logic [9:0] VGA_IO_LO_B = 10'h3c0;
  localparam logic [9:0] VGA_IO_HI_B = 10'h3df;
  localparam logic [9:0] MONO_IO_P0 = 10'h3b4;
  localparam logic [9:0] MONO_IO_P1 = 10'h3b5;
  localparam logic [9:0] MONO_IO_P2 = 10'h3b8;
  localparam logic [9:0] MONO_IO_P3 = 10'h3b9;
  localparam logic [9:0] MONO_IO_P4 = 10'h3ba;
  localparam logic [9:0] MONO_IO_P5 = 10'h3bf;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] cause;
  } serr_msg_t;

  typedef struct packed {
    logic valid;
    logic is_io;
    logic [31:0] addr;
  } route_req_t;

  typedef struct packed {
    logic valid;
    logic to_agp;
    logic vga_hit;
    logic mono_hit;
  } route_res_t;

  typedef enum logic {MSG_IDLE, MSG_SEND} msg_state_t;

endpackage : serr_pkg
`default_nettype wire

// File: sim/hub_msg_sink.sv
// Hub-side model that accepts error messages promptly or after a short random delay
`default_nettype none
module hub_msg_sink (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic msg_valid,
  input wire logic slow,
  output logic msg_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lfsr_q;
  logic [2:0] wait_q;
  // ----------------------------------------
  // Acceptance: one ready pulse per message
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      msg_ready <= 1'b0;
      wait_q <= 3'h0;
      lfsr_q <= 8'h5a;
    end
    else
    begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      if (msg_ready || !msg_valid)
      begin
        msg_ready <= 1'b0;
        wait_q <= 3'h0;
      end
      else if (!slow || wait_q >= {1'b0, lfsr_q[1:0]})
        msg_ready <= 1'b1;
      else
        wait_q <= wait_q + 3'h1;
    end
  end
endmodule : hub_msg_sink
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the error message and display routing block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [serr_pkg::COND_N-1:0] err_event = 6'h00;
  logic msg_valid;
  serr_pkg::serr_msg_t msg;
  logic msg_ready;
  logic slow = 1'b0;
  serr_pkg::route_req_t route_req = '0;
  serr_pkg::route_res_t route_res;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rng = 32'd89;
  logic [31:0] rd;
  logic [2:0] rxq[$];
  logic [9:0] regs[4] = '{serr_pkg::ADDR_ERR_EN, serr_pkg::ADDR_BRIDGE_CTRL,
                          serr_pkg::ADDR_HUB_CFG, 10'h3fc};
  logic [31:0] masks[4] = '{32'h0000_003f, 32'h0000_00ff, 32'h0000_0007, 32'h0000_0000};
  logic [9:0] mono_ports[6] = '{10'h3b4, 10'h3b5, 10'h3b8, 10'h3b9, 10'h3ba, 10'h3bf};

  serr_error_report dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .err_event(err_event),
    .msg_valid(msg_valid), .msg(msg), .msg_ready(msg_ready), .route_req(route_req),
    .route_res(route_res)
  );
  hub_msg_sink sink_u (
    .hclk(hclk), .hresetn(hresetn), .msg_valid(msg_valid), .slow(slow),
    .msg_ready(msg_ready)
  );

  always #25 hclk = ~hclk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  function automatic logic [3:0] exp_route(input logic io, input logic [31:0] a,
                                           input logic vga, input logic mono);
    logic vh;
    logic mh;
    logic [9:0] p;
    p = a[9:0];
    if (io)
    begin
      vh = (p >= 10'h3b0 && p <= 10'h3bb) || (p >= 10'h3c0 && p <= 10'h3df);
      mh = p inside {10'h3b4, 10'h3b5, 10'h3b8, 10'h3b9, 10'h3ba, 10'h3bf};
    end
    else
    begin
      vh = a >= 32'h000a_0000 && a <= 32'h000b_ffff;
      mh = a >= 32'h000b_0000 && a <= 32'h000b_7fff;
    end
    return {1'b1, vga & vh & ~(mono & mh), vh, mh};
  endfunction : exp_route

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Waits for hready at a rising edge and takes read data at that same edge
  task automatic wait_ready;
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h000000, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask : bus

  task automatic route_one(input logic io, input logic [31:0] a, input logic [1:0] c);
    route_req <= {1'b1, io, a};
    @(posedge hclk);
    route_req <= '0;
    @(negedge hclk);
    chk({28'h0, route_res}, {28'h0, exp_route(io, a, c[1], c[0])}, "route");
    @(posedge hclk);
  endtask : route_one

  task automatic occur(input logic [5:0] bits);
    rng = xs(rng);
    err_event <= bits;
    repeat (1 + rng[1:0]) @(posedge hclk);
    err_event <= 6'h00;
    repeat (30) @(posedge hclk);
  endtask : occur

  task automatic chk_msg(input logic [11:0] causes, input logic [7:0] n);
    logic [31:0] g;
    g = 32'h0;
    g[31:24] = 8'(rxq.size());
    foreach (rxq[j])
      if (j < 3)
        g[j*4 +: 4] = {1'b0, rxq[j]};
    chk(g, {n, 12'h000, causes}, "messages");
    rxq.delete();
  endtask : chk_msg

  always @(posedge hclk)
    if (msg_valid === 1'b1 && msg_ready === 1'b1)
      rxq.push_back(msg.cause);

  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("mismatch at %0t: timeout", $time);
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int r = 0; r < 4; r++)
    begin
      bus(1'b0, regs[r], 32'h0);
      chk(rd, 32'h0, "reset value");
      rng = xs(rng);
      bus(1'b1, regs[r], rng);
      bus(1'b0, regs[r], 32'h0);
      chk(rd, rng & masks[r], "readback");
    end
    $display("test registers done");
    for (int c = 0; c < 4; c++)
    begin
      if (c == 1)
        continue; // present without VGA enable is never programmed
      bus(1'b1, serr_pkg::ADDR_BRIDGE_CTRL, {28'h0, c[1], 3'h0});
      bus(1'b1, serr_pkg::ADDR_HUB_CFG, {29'h0, c[0], 2'h0});
      for (int k = 0; k < 16; k++)
      begin
        rng = xs(rng);
        case (k % 4)
          0: route_one(1'b0, {17'h00016, rng[14:0]}, c[1:0]);
          1: route_one(1'b0, {16'h000a, rng[15:0]}, c[1:0]);
          2: route_one(1'b1, {16'h0, rng[15:10], mono_ports[rng[18:16] % 6]}, c[1:0]);
          default: route_one(1'b1, {16'h0, rng[15:10], 5'h1e, rng[4:0]}, c[1:0]);
        endcase
      end
    end
    $display("test routing done");
    // SMI and SCI paths lie outside this block
    bus(1'b1, serr_pkg::ADDR_HUB_CFG, 32'h0000_0003);
    for (int i = 0; i < 6; i++)
    begin
      slow <= i[0];
      bus(1'b1, serr_pkg::ADDR_ERR_EN, 32'h1 << i);
      occur(6'h01 << i);
      chk_msg(12'(i), 8'h01);
    end
    $display("test messages done");
    for (int g = 0; g < 3; g++)
    begin
      rng = xs(rng);
      bus(1'b1, serr_pkg::ADDR_HUB_CFG, g == 0 ? 32'h2 : (g == 1 ? 32'h1 : 32'h3));
      bus(1'b1, serr_pkg::ADDR_ERR_EN, g == 2 ? 32'h3f & ~(32'h1 << (rng % 6)) : 32'h3f);
      occur(6'h01 << (rng % 6));
      chk_msg(12'h000, 8'h00);
    end
    $display("test gating done");
    slow <= 1'b1;
    bus(1'b1, serr_pkg::ADDR_ERR_EN, 32'h3f);
    occur(6'h12);
    chk_msg(12'h041, 8'h02);
    $display("test ordering done");
    // New occurrence lands in the accept cycle of its own message
    slow <= 1'b0;
    err_event <= 6'h10;
    @(posedge hclk);
    err_event <= 6'h00;
    repeat (2) @(posedge hclk);
    err_event <= 6'h10;
    @(posedge hclk);
    err_event <= 6'h00;
    repeat (30) @(posedge hclk);
    chk_msg(12'h044, 8'h02);
    bus(1'b0, serr_pkg::ADDR_MSG_STAT, 32'h0);
    chk(rd, 32'h000a_0000, "status");
    $display("test set wins done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
